//--- verilog/wrw_defs.svh
// constants of the windowed reset watchdog: offsets, reset values, timing
// assumes a 25 MHz cpu clock; included by bare name
`ifndef WRW_DEFS_SVH
`define WRW_DEFS_SVH

`define WRW_CTRL_IDX    6'h0d
`define WRW_CTRL_ADDR   {`WRW_CTRL_IDX, 2'b00}
`define WRW_CTRL_RESET  8'h7f
`define WRW_ACT_BIT     7
`define WRW_TOP_BIT     6
`define WRW_ROLL_FROM   7'h40
`define WRW_PRESCALE    65536
`define WRW_CLK_NS      40
`define WRW_PULSE_NS    30000
`define WRW_PULSE_CYC   ((`WRW_PULSE_NS + `WRW_CLK_NS - 1) / `WRW_CLK_NS)
`define WRW_WAKE_CYC    514
`define WRW_TIME_W      10

`endif

//--- verilog/wrw_pkg.sv
// types of the windowed reset watchdog
// assumes nothing beyond a sv compiler
`include "wrw_defs.svh"

package wrw_pkg;

  typedef enum logic [1:0] {
    wrw_run,
    wrw_halt,
    wrw_wake
  } wrw_pwr_t;

  typedef logic [`WRW_TIME_W-1:0] wrw_time_t;

endpackage

//--- verilog/wrw_tick.sv
// machine cycle prescaler: one-cycle tick every div enabled cycles
// assumes clk is the cpu clock and en comes from the same domain
`timescale 1ns/1ps
`include "wrw_defs.svh"

module wrw_tick #(
  parameter int unsigned DIV = `WRW_PRESCALE
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic en,
  output logic      tick
);

  localparam logic [15:0] LAST = 16'(DIV - 1);

  logic [15:0] pre_q;
  logic        tick_q;
  wire         wrap = en && (pre_q == LAST);

  // frozen while disabled so a halt does not lose the partial period
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= wrap;
      if (wrap) begin
        pre_q <= 16'h0000;
      end else if (en) begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  assign tick = tick_q;

endmodule // wrw_tick

//--- verilog/wrw_top.sv
// windowed reset watchdog with apb register access
// assumes one 25 MHz clock, synchronous reset, halt from the cpu core on the same clock,
// ext_irq and the mode strap from pins
//
// What this block does
// - count down one step every 65,536 machine cycles
// - when active, rollover 40h to 3Fh drives reset pin low for 30 us
// - counter runs whether active or not; activation only gates the reset
// - six low written bits set steps left before top bit clears
// - software mode: inactive after reset, only reset can deactivate
// - write with activate set and top bit clear resets at once
// - hardware mode: always active, activate bit ignored
// - wait mode no effect; halt stops counting and resets until interrupt
// - after wake on external interrupt wait 514 clocks before counting
// - control register resets to 7Fh
// - activate bit set only by software, cleared only by reset
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "wrw_defs.svh"

module wrw_top #(
  parameter int unsigned PRESCALE = `WRW_PRESCALE
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        hw_mode_strap,
  input  wire logic        halt,
  input  wire logic        ext_irq,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             reset_pin_n,
  output logic             wdg_active
);

  localparam wrw_pkg::wrw_time_t PULSE_CYC = `WRW_TIME_W'(`WRW_PULSE_CYC);
  localparam wrw_pkg::wrw_time_t WAKE_LAST = `WRW_TIME_W'(`WRW_WAKE_CYC - 1);

  // pin synchronisers
  logic strap_m_q;
  logic strap_s_q;
  logic irq_m_q;
  logic irq_s_q;

  // no reset on the strap pair: it must settle while reset is held, or the capture sees a stale value
  always_ff @(posedge clk) begin
    strap_m_q <= hw_mode_strap;
    strap_s_q <= strap_m_q;
  end

  // irq pair resets to the idle level of the pin, so no false wake follows reset
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_m_q <= 1'b0;
      irq_s_q <= 1'b0;
    end else begin
      irq_m_q <= ext_irq;
      irq_s_q <= irq_m_q;
    end
  end

  // option caught while reset is held; sync reset means the clock runs then
  logic hw_mode_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      hw_mode_q <= strap_s_q;
    end
  end

  // apb slave: one wait state so every output comes from a flop
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        act_q;
  logic [6:0]  cnt_q;

  wire         acc      = psel && penable;
  wire         acc_wait = acc && !pready_q;
  wire         acc_done = acc && pready_q;
  wire         hit      = (paddr == `WRW_CTRL_ADDR);
  wire         wr_ctrl  = acc_done && pwrite && hit;
  wire [31:0]  rd_word  = {24'h000000, act_q, cnt_q};

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= acc_wait;
      pslverr_q <= acc_wait && !hit;
      if (acc_wait) begin
        prdata_q <= (hit && !pwrite) ? rd_word : 32'h00000000;
      end
    end
  end

  // power state: halt freezes the counter, wake waits before resuming
  wrw_pkg::wrw_pwr_t pwr_q;
  wrw_pkg::wrw_pwr_t pwr_d;
  wrw_pkg::wrw_time_t wake_q;
  wire wake_done = (wake_q == WAKE_LAST);

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      wrw_pkg::wrw_run: begin
        if (halt) begin
          pwr_d = wrw_pkg::wrw_halt;
        end
      end
      wrw_pkg::wrw_halt: begin
        if (irq_s_q) begin
          pwr_d = wrw_pkg::wrw_wake;
        end
      end
      wrw_pkg::wrw_wake: begin
        if (wake_done) begin
          pwr_d = wrw_pkg::wrw_run;
        end
      end
      default: begin
        pwr_d = wrw_pkg::wrw_run;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_q  <= wrw_pkg::wrw_run;
      wake_q <= '0;
    end else begin
      pwr_q  <= pwr_d;
      wake_q <= (pwr_q == wrw_pkg::wrw_wake) ? wake_q + 1'b1 : '0;
    end
  end

  // wait mode is not an input at all: it has no effect on counting
  wire cnt_en = (pwr_q == wrw_pkg::wrw_run);
  logic tick;

  // limitation: a tick earned in the very cycle halt begins is dropped, one step per such halt

  wrw_tick #(
    .DIV (PRESCALE)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .en    (cnt_en),
    .tick  (tick)
  );

  // control register
  wire       step    = tick && cnt_en;
  wire       eff_act = act_q || hw_mode_q;
  wire       wr_act  = pwdata[`WRW_ACT_BIT] || eff_act;
  wire       roll    = step && (cnt_q == `WRW_ROLL_FROM) && !wr_ctrl;
  wire       sw_rst  = wr_ctrl && wr_act && !pwdata[`WRW_TOP_BIT];
  wire       fire    = (roll && eff_act) || sw_rst;
  logic      act_d;
  logic [6:0] cnt_d;

  always_comb begin
    act_d = act_q || (wr_ctrl && pwdata[`WRW_ACT_BIT]);
    cnt_d = cnt_q;
    if (wr_ctrl) begin
      cnt_d = pwdata[6:0];
    end else if (step) begin
      cnt_d = cnt_q - 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      act_q <= 1'(`WRW_CTRL_RESET >> `WRW_ACT_BIT);
      cnt_q <= 7'(`WRW_CTRL_RESET);
    end else begin
      act_q <= act_d;
      cnt_q <= cnt_d;
    end
  end

  // reset pulse; a retrigger restarts the full width
  wrw_pkg::wrw_time_t pulse_q;
  wrw_pkg::wrw_time_t pulse_d;
  logic rst_n_q;
  logic active_q;

  always_comb begin
    pulse_d = pulse_q;
    if (fire) begin
      pulse_d = PULSE_CYC;
    end else if (pulse_q != '0) begin
      pulse_d = pulse_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_q  <= '0;
      rst_n_q  <= 1'b1;
      active_q <= 1'b0;
    end else begin
      pulse_q  <= pulse_d;
      rst_n_q  <= (pulse_d == '0);
      active_q <= act_d || hw_mode_q;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign reset_pin_n = rst_n_q;
  assign wdg_active  = active_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  wrw_pkg::wrw_time_t low_len_q;

  always_ff @(posedge clk) begin
    if (reset || rst_n_q) begin
      low_len_q <= '0;
    end else begin
      low_len_q <= low_len_q + 1'b1;
    end
  end

  sequence seq_wake_start;
    (pwr_q == wrw_pkg::wrw_halt) && irq_s_q;
  endsequence

  sequence seq_refresh_write;
    wr_ctrl && pwdata[`WRW_TOP_BIT];
  endsequence

  sequence seq_activate_write;
    wr_ctrl && pwdata[`WRW_ACT_BIT];
  endsequence

  AST_DECREMENT: assert property (step && !wr_ctrl |=> cnt_q == $past(cnt_q) - 7'h01)
    else $error("counter did not step down on tick");

  AST_ROLL_RESET: assert property (roll && eff_act |=> !rst_n_q)
    else $error("rollover while active gave no reset");

  AST_PULSE_WIDTH: assert property ($rose(rst_n_q) |-> low_len_q == PULSE_CYC)
    else $error("reset pulse width wrong");

  AST_FREE_RUN: assert property (step && !eff_act && !wr_ctrl |=> cnt_q != $past(cnt_q))
    else $error("counter stopped while inactive");

  AST_QUIET_IDLE: assert property (roll && !eff_act && pulse_q == '0 |=> rst_n_q)
    else $error("inactive watchdog caused reset");

  AST_LOAD: assert property (seq_refresh_write |=> cnt_q == $past(pwdata[6:0]))
    else $error("refresh value not loaded");

  AST_STICKY: assert property (act_q |=> act_q [*2])
    else $error("activation bit cleared without reset");

  AST_SW_RESET: assert property (wr_ctrl && pwdata[`WRW_ACT_BIT] && !pwdata[`WRW_TOP_BIT] |=> !rst_n_q)
    else $error("software reset not produced");

  AST_HW_MODE: assert property (hw_mode_q && wr_ctrl && !pwdata[`WRW_TOP_BIT] |=> !rst_n_q)
    else $error("hardware mode ignored top bit clear");

  AST_HALT_FROZEN: assert property (pwr_q != wrw_pkg::wrw_run && !wr_ctrl |=> $stable(cnt_q) && rst_n_q || pulse_q != '0)
    else $error("counter moved or reset in halt");

  AST_WAKE_DELAY: assert property (seq_wake_start |-> ##[515:515] (pwr_q == wrw_pkg::wrw_run))
    else $error("wake delay not 514 clocks");

  AST_RESET_VALUE: assert property ($past(reset) |-> cnt_q == 7'(`WRW_CTRL_RESET) && !act_q)
    else $error("control register reset value wrong");

  // activation, mode, pulse end and wake checks
  AST_ACT_SET: assert property (seq_activate_write |=> act_q)
    else $error("activation bit not set by write");

  AST_HW_ACTIVE: assert property (hw_mode_q |=> active_q)
    else $error("hardware mode not shown as active");

  AST_PULSE_IDLE: assert property (pulse_q == '0 && !fire |=> rst_n_q)
    else $error("reset pin low with no pulse pending");

  AST_WAKE_HOLD: assert property (seq_wake_start |=> pwr_q == wrw_pkg::wrw_wake && !cnt_en)
    else $error("counting resumed at once after wake");

endmodule // wrw_top

//--- sim/wrw_top_tb_top.sv
// bench for the windowed reset watchdog: apb tasks and directed sequences
// assumes the design elaborated with a short prescale so ticks come every 16 cycles
`timescale 1ns/1ps
`include "wrw_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module wrw_top_tb_top;
  localparam int unsigned PRE = 16;
  logic        clk, reset, hw_mode_strap, halt, ext_irq;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, reset_pin_n, wdg_active, err;
  logic [7:0]  c1;
  int          error_cnt, n_compared, cyc, lo;

  wrw_top #(.PRESCALE(PRE)) wrw_top_inst (.clk(clk), .reset(reset), .hw_mode_strap(hw_mode_strap),
    .halt(halt), .ext_irq(ext_irq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
    .wdg_active(wdg_active));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  task end_sim;
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the longest sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end

  // entered right after a rising edge; holds the request until pready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask

  task rst(input logic hw);
    reset <= 1; hw_mode_strap <= hw;
    repeat (6) @(posedge clk);
    reset <= 0;
    repeat (2) @(posedge clk);
  endtask

  // waits up to max cycles for the pulse, then times its low phase
  task pulse(input int max);
    int n;
    n = 0;
    while (reset_pin_n !== 1'b0 && n < max) begin @(posedge clk); n++; end
    lo = 0;
    while (reset_pin_n === 1'b0 && lo < 2000) begin @(posedge clk); lo++; end
  endtask

  initial begin
    {reset, hw_mode_strap, halt, ext_irq, psel, penable, pwrite} = 7'h40;
    paddr = 8'h00; pwdata = 32'h0;
    rst(0);
    apb(0, `WRW_CTRL_ADDR, 0);
    `CHK(rd, 32'h7f)
    `CHK(wdg_active, 1'b0)
    apb(0, 8'h10, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // inactive: counter crosses 40h with no pulse
    apb(1, `WRW_CTRL_ADDR, 32'h41);
    repeat (60) @(posedge clk);
    `CHK(reset_pin_n, 1'b1)
    apb(0, `WRW_CTRL_ADDR, 0);
    `CHK(rd[7:0] inside {[8'h3c:8'h3e]}, 1'b1)
    // armed with one step left: second tick fires
    apb(1, `WRW_CTRL_ADDR, 32'hc1);
    repeat (10) @(posedge clk);
    `CHK(reset_pin_n, 1'b1)
    `CHK(wdg_active, 1'b1)
    pulse(40);
    `CHK(lo, 750)
    apb(1, `WRW_CTRL_ADDR, 32'h7f);
    apb(0, `WRW_CTRL_ADDR, 0);
    `CHK(rd[7], 1'b1)
    // halt freezes the count, wake waits before counting resumes
    apb(1, `WRW_CTRL_ADDR, 32'hff);
    halt <= 1;
    repeat (3) @(posedge clk);
    apb(0, `WRW_CTRL_ADDR, 0);
    c1 = rd[7:0];
    repeat (100) @(posedge clk);
    apb(0, `WRW_CTRL_ADDR, 0);
    `CHK(rd[7:0], c1)
    ext_irq <= 1; halt <= 0;
    repeat (400) @(posedge clk);
    ext_irq <= 0;
    apb(0, `WRW_CTRL_ADDR, 0);
    `CHK(rd[7:0], c1)
    repeat (300) @(posedge clk);
    apb(0, `WRW_CTRL_ADDR, 0);
    `CHK(rd[7:0] < c1, 1'b1)
    // software reset: top bit cleared while armed
    apb(1, `WRW_CTRL_ADDR, 32'h80);
    pulse(3);
    `CHK(lo, 750)
    // reset clears activation in software mode
    rst(0);
    `CHK(wdg_active, 1'b0)
    // hardware mode ignores the activation bit
    rst(1);
    `CHK(wdg_active, 1'b1)
    apb(1, `WRW_CTRL_ADDR, 32'h00);
    pulse(3);
    `CHK(lo, 750)
    end_sim;
  end
endmodule // wrw_top_tb_top
